// ==== rtl/dsp_startup_config_sequencer.sv ====
module dsp_startup_config_sequencer #(
  parameter int LOCK_CYCLES = dsp_startup_pkg::PLL_LOCK_CYCLES,
  parameter int INIT_CYCLES = dsp_startup_pkg::CORE_INIT_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        slave_select_addr0_pin,
  input  wire logic [15:0] ctl_addr,
  input  wire logic [15:0] ctl_wdata,
  input  wire logic        ctl_wr,
  input  wire logic        ctl_rd,
  output logic [15:0]      ctl_rdata_q,
  output logic             ctl_ack_q,
  output logic             spi_mode_q,
  output logic             buffered_clock_pin,
  output logic             soft_reset_q,
  output logic             pll_locked_q,
  output logic             core_active_q,
  output logic             core_init_busy_q,
  output logic             mem_wr_q,
  output logic             mem_page_q,
  output logic [15:0]      mem_addr_q,
  output logic [15:0]      mem_wdata_q,
  output logic [15:0]      power_mask_a_q,
  output logic [15:0]      power_mask_b_q
);
  //==============================================================
  // state
  logic [15:0] fb_div_q, fb_div_d;
  logic [15:0] prediv_q, prediv_d;
  logic [15:0] clk_src_q, clk_src_d;
  logic [15:0] run_reg_q, run_reg_d;
  logic [15:0] buffered_clock_pin_cfg_q, buffered_clock_pin_cfg_d;
  logic [15:0] power_mask_a_d, power_mask_b_d;
  logic [15:0] hibernate_q, hibernate_d;
  logic [15:0] frame_trig_q, frame_trig_d;
  logic [15:0] core_run_q, core_run_d;
  logic [15:0] entry_q, entry_d;
  logic [15:0] restart_q, restart_d;
  logic [15:0] page_q, page_d;
  logic [15:0] ctl_rdata_d;
  logic        ctl_ack_d;
  logic        ss_prev_q, ss_prev_d;
  logic [1:0]  ss_rises_q, ss_rises_d;
  logic        cfg_started_q, cfg_started_d;
  logic        spi_mode_d;
  dsp_startup_pkg::pll_state_e pll_q, pll_d;
  logic [31:0] lock_cnt_q, lock_cnt_d;
  logic [31:0] init_cnt_q, init_cnt_d;
  logic        core_init_busy_d;
  logic        core_active_d;
  logic        mem_wr_d;
  logic [15:0] mem_addr_d, mem_wdata_d;
  logic        wr_ok;
  logic        reg_wr;

  //==============================================================
  // control port, register file, PLL and core sequencing
  always_comb begin
    fb_div_d       = fb_div_q;
    prediv_d       = prediv_q;
    clk_src_d      = clk_src_q;
    run_reg_d      = run_reg_q;
    buffered_clock_pin_cfg_d   = buffered_clock_pin_cfg_q;
    power_mask_a_d = power_mask_a_q;
    power_mask_b_d = power_mask_b_q;
    hibernate_d    = hibernate_q;
    frame_trig_d   = frame_trig_q;
    core_run_d     = core_run_q;
    entry_d        = entry_q;
    restart_d      = restart_q;
    page_d         = page_q;
    ctl_rdata_d    = ctl_rdata_q;
    ctl_ack_d      = ctl_wr | ctl_rd;
    ss_prev_d      = slave_select_addr0_pin;
    ss_rises_d     = ss_rises_q;
    cfg_started_d  = cfg_started_q;
    spi_mode_d     = spi_mode_q;
    pll_d          = pll_q;
    lock_cnt_d     = lock_cnt_q;
    init_cnt_d     = init_cnt_q;
    mem_wr_d       = 1'b0;
    mem_addr_d     = mem_addr_q;
    mem_wdata_d    = mem_wdata_q;
    // writes are dropped while the PLL relocks; the port still answers
    wr_ok  = ctl_wr && (pll_q != dsp_startup_pkg::PLL_LOCKING);
    reg_wr = wr_ok && (ctl_addr >= dsp_startup_pkg::ADDR_REG_SPACE_BASE);

    // mode pin only counts until the first configuration write
    if (!cfg_started_q && slave_select_addr0_pin && !ss_prev_q) begin
      if (ss_rises_q == 2'(dsp_startup_pkg::SPI_TOGGLE_COUNT - 1))
        spi_mode_d = 1'b1;
      else
        ss_rises_d = ss_rises_q + 2'd1;
    end
    if (ctl_wr)
      cfg_started_d = 1'b1;

    // lock timer models the worst-case acquisition time
    unique case (pll_q)
      dsp_startup_pkg::PLL_OFF: ;
      dsp_startup_pkg::PLL_LOCKING: begin
        if (lock_cnt_q <= 32'd1)
          pll_d = dsp_startup_pkg::PLL_LOCKED;
        else
          lock_cnt_d = lock_cnt_q - 32'd1;
      end
      dsp_startup_pkg::PLL_LOCKED: ;
    endcase

    if (init_cnt_q != 32'd0)
      init_cnt_d = init_cnt_q - 32'd1;

    if (wr_ok && !reg_wr) begin
      // memory writes carry bit 0 of the selected page out to the memory arrays
      mem_wr_d    = 1'b1;
      mem_addr_d  = ctl_addr;
      mem_wdata_d = ctl_wdata;
    end

    if (reg_wr) begin
      unique case (ctl_addr)
        dsp_startup_pkg::ADDR_PLL_FEEDBACK_DIVIDER:  fb_div_d = ctl_wdata;
        dsp_startup_pkg::ADDR_PLL_INPUT_PREDIVIDER:  prediv_d = ctl_wdata;
        dsp_startup_pkg::ADDR_CORE_CLOCK_SOURCE_SEL: clk_src_d = ctl_wdata;
        dsp_startup_pkg::ADDR_PLL_RUN_BIT: begin
          run_reg_d = ctl_wdata;
          if (ctl_wdata[dsp_startup_pkg::RUN_BIT_POS]) begin
            pll_d      = dsp_startup_pkg::PLL_LOCKING;
            lock_cnt_d = 32'(LOCK_CYCLES);
          end else begin
            pll_d = dsp_startup_pkg::PLL_OFF;
          end
        end
        dsp_startup_pkg::ADDR_CLOCK_OUTPUT_CONFIG:   buffered_clock_pin_cfg_d = ctl_wdata;
        dsp_startup_pkg::ADDR_SUBSYSTEM_POWER_A:     power_mask_a_d = ctl_wdata;
        dsp_startup_pkg::ADDR_SUBSYSTEM_POWER_B:     power_mask_b_d = ctl_wdata;
        dsp_startup_pkg::ADDR_HIBERNATE:             hibernate_d = ctl_wdata;
        dsp_startup_pkg::ADDR_CORE_FRAME_TRIGGER:    frame_trig_d = ctl_wdata;
        dsp_startup_pkg::ADDR_CORE_RUN_CONTROL: begin
          core_run_d = ctl_wdata;
          if (ctl_wdata[dsp_startup_pkg::RUN_BIT_POS] && !core_run_q[dsp_startup_pkg::RUN_BIT_POS])
            init_cnt_d = 32'(INIT_CYCLES);
          else if (!ctl_wdata[dsp_startup_pkg::RUN_BIT_POS])
            init_cnt_d = 32'd0;
        end
        dsp_startup_pkg::ADDR_PROGRAM_ENTRY_POINT:   entry_d = ctl_wdata;
        dsp_startup_pkg::ADDR_LOGIC_RESTART_CTL:     restart_d = ctl_wdata;
        dsp_startup_pkg::ADDR_MEMORY_PAGE_SELECT:    page_d = ctl_wdata;
        default: ;
      endcase
    end

    if (ctl_rd) begin
      unique case (ctl_addr)
        dsp_startup_pkg::ADDR_PLL_FEEDBACK_DIVIDER:  ctl_rdata_d = fb_div_q;
        dsp_startup_pkg::ADDR_PLL_INPUT_PREDIVIDER:  ctl_rdata_d = prediv_q;
        dsp_startup_pkg::ADDR_CORE_CLOCK_SOURCE_SEL: ctl_rdata_d = clk_src_q;
        dsp_startup_pkg::ADDR_PLL_RUN_BIT:           ctl_rdata_d = run_reg_q;
        dsp_startup_pkg::ADDR_PLL_LOCK_STATUS: begin
          ctl_rdata_d = 16'h0000;
          ctl_rdata_d[dsp_startup_pkg::LOCK_BIT_POS] = (pll_q == dsp_startup_pkg::PLL_LOCKED);
        end
        dsp_startup_pkg::ADDR_CLOCK_OUTPUT_CONFIG:   ctl_rdata_d = buffered_clock_pin_cfg_q;
        dsp_startup_pkg::ADDR_SUBSYSTEM_POWER_A:     ctl_rdata_d = power_mask_a_q;
        dsp_startup_pkg::ADDR_SUBSYSTEM_POWER_B:     ctl_rdata_d = power_mask_b_q;
        dsp_startup_pkg::ADDR_HIBERNATE:             ctl_rdata_d = hibernate_q;
        dsp_startup_pkg::ADDR_CORE_FRAME_TRIGGER:    ctl_rdata_d = frame_trig_q;
        dsp_startup_pkg::ADDR_CORE_RUN_CONTROL:      ctl_rdata_d = core_run_q;
        dsp_startup_pkg::ADDR_PROGRAM_ENTRY_POINT:   ctl_rdata_d = entry_q;
        dsp_startup_pkg::ADDR_LOGIC_RESTART_CTL:     ctl_rdata_d = restart_q;
        dsp_startup_pkg::ADDR_MEMORY_PAGE_SELECT:    ctl_rdata_d = page_q;
        default:                                     ctl_rdata_d = 16'h0000;
      endcase
    end

    core_init_busy_d = (init_cnt_d != 32'd0);
    core_active_d    = core_run_d[dsp_startup_pkg::RUN_BIT_POS] && !hibernate_d[dsp_startup_pkg::RUN_BIT_POS];
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      // 96 on the divide-by-4 prescaled input gives a core clock of 24x the input
      fb_div_q         <= dsp_startup_pkg::RST_PLL_FEEDBACK_DIVIDER;
      prediv_q         <= dsp_startup_pkg::RST_ZERO;
      clk_src_q        <= dsp_startup_pkg::RST_ZERO;
      run_reg_q        <= dsp_startup_pkg::RST_ZERO;
      buffered_clock_pin_cfg_q     <= dsp_startup_pkg::RST_ZERO;
      power_mask_a_q   <= dsp_startup_pkg::RST_ZERO;
      power_mask_b_q   <= dsp_startup_pkg::RST_ZERO;
      hibernate_q      <= dsp_startup_pkg::RST_ZERO;
      frame_trig_q     <= dsp_startup_pkg::RST_ZERO;
      core_run_q       <= dsp_startup_pkg::RST_ZERO;
      entry_q          <= dsp_startup_pkg::RST_ZERO;
      restart_q        <= dsp_startup_pkg::RST_LOGIC_RESTART_CTL;
      page_q           <= dsp_startup_pkg::RST_ZERO;
      ctl_rdata_q      <= 16'h0000;
      ctl_ack_q        <= 1'b0;
      ss_prev_q        <= 1'b0;
      ss_rises_q       <= 2'd0;
      cfg_started_q    <= 1'b0;
      spi_mode_q       <= 1'b0;
      pll_q            <= dsp_startup_pkg::PLL_OFF;
      lock_cnt_q       <= 32'd0;
      init_cnt_q       <= 32'd0;
      pll_locked_q     <= 1'b0;
      soft_reset_q     <= 1'b0;
      core_active_q    <= 1'b0;
      core_init_busy_q <= 1'b0;
      mem_wr_q         <= 1'b0;
      mem_page_q       <= 1'b0;
      mem_addr_q       <= 16'h0000;
      mem_wdata_q      <= 16'h0000;
    end else begin
      fb_div_q         <= fb_div_d;
      prediv_q         <= prediv_d;
      clk_src_q        <= clk_src_d;
      run_reg_q        <= run_reg_d;
      buffered_clock_pin_cfg_q     <= buffered_clock_pin_cfg_d;
      power_mask_a_q   <= power_mask_a_d;
      power_mask_b_q   <= power_mask_b_d;
      hibernate_q      <= hibernate_d;
      frame_trig_q     <= frame_trig_d;
      core_run_q       <= core_run_d;
      entry_q          <= entry_d;
      restart_q        <= restart_d;
      page_q           <= page_d;
      ctl_rdata_q      <= ctl_rdata_d;
      ctl_ack_q        <= ctl_ack_d;
      ss_prev_q        <= ss_prev_d;
      ss_rises_q       <= ss_rises_d;
      cfg_started_q    <= cfg_started_d;
      spi_mode_q       <= spi_mode_d;
      pll_q            <= pll_d;
      lock_cnt_q       <= lock_cnt_d;
      init_cnt_q       <= init_cnt_d;
      pll_locked_q     <= (pll_d == dsp_startup_pkg::PLL_LOCKED);
      soft_reset_q     <= !restart_d[dsp_startup_pkg::RUN_BIT_POS];
      core_active_q    <= core_active_d;
      core_init_busy_q <= core_init_busy_d;
      mem_wr_q         <= mem_wr_d;
      mem_page_q       <= page_d[0];
      mem_addr_q       <= mem_addr_d;
      mem_wdata_q      <= mem_wdata_d;
    end
  end

  //==============================================================
  // buffered clock output, steered only by its config register
  buffered_clock_pin_gen #(
    .SEL_W (dsp_startup_pkg::BUFFERED_CLOCK_PIN_SEL_W)
  ) u_buffered_clock_pin (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .enable    (buffered_clock_pin_cfg_q[dsp_startup_pkg::BUFFERED_CLOCK_PIN_EN_POS]),
    .sel       (buffered_clock_pin_cfg_q[dsp_startup_pkg::BUFFERED_CLOCK_PIN_SEL_LSB +: dsp_startup_pkg::BUFFERED_CLOCK_PIN_SEL_W]),
    .clk_out_q (buffered_clock_pin)
  );
endmodule

// ==== rtl/dsp_startup_pkg.sv ====
//==============================================================
package dsp_startup_pkg;
  //==============================================================
  // register offsets
  localparam logic [15:0] ADDR_PLL_FEEDBACK_DIVIDER  = 16'hf000;
  localparam logic [15:0] ADDR_PLL_INPUT_PREDIVIDER  = 16'hf001;
  localparam logic [15:0] ADDR_CORE_CLOCK_SOURCE_SEL = 16'hf002;
  localparam logic [15:0] ADDR_PLL_RUN_BIT           = 16'hf003;
  localparam logic [15:0] ADDR_PLL_LOCK_STATUS       = 16'hf004;
  localparam logic [15:0] ADDR_CLOCK_OUTPUT_CONFIG   = 16'hf005;
  localparam logic [15:0] ADDR_SUBSYSTEM_POWER_A     = 16'hf050;
  localparam logic [15:0] ADDR_SUBSYSTEM_POWER_B     = 16'hf051;
  localparam logic [15:0] ADDR_HIBERNATE             = 16'hf400;
  localparam logic [15:0] ADDR_CORE_FRAME_TRIGGER    = 16'hf401;
  localparam logic [15:0] ADDR_CORE_RUN_CONTROL      = 16'hf402;
  localparam logic [15:0] ADDR_PROGRAM_ENTRY_POINT   = 16'hf404;
  localparam logic [15:0] ADDR_LOGIC_RESTART_CTL     = 16'hf890;
  localparam logic [15:0] ADDR_MEMORY_PAGE_SELECT    = 16'hf899;
  // addresses below this are memory, at and above are registers
  localparam logic [15:0] ADDR_REG_SPACE_BASE        = 16'hf000;
  //==============================================================
  // reset values
  localparam logic [15:0] RST_PLL_FEEDBACK_DIVIDER   = 16'h0060;
  localparam logic [15:0] RST_LOGIC_RESTART_CTL      = 16'h0001;
  localparam logic [15:0] RST_ZERO                   = 16'h0000;
  //==============================================================
  // field positions
  localparam int RUN_BIT_POS      = 0;
  localparam int LOCK_BIT_POS     = 0;
  localparam int BUFFERED_CLOCK_PIN_EN_POS    = 0;
  localparam int BUFFERED_CLOCK_PIN_SEL_LSB   = 1;
  localparam int BUFFERED_CLOCK_PIN_SEL_W     = 2;
  localparam int SPI_TOGGLE_COUNT = 3;
  //==============================================================
  // timing
  localparam int  SYS_CLK_HZ      = 50_000_000;
  localparam real PLL_LOCK_MS     = 10.666;
  localparam real CORE_INIT_US    = 50.0;
  // longest lock time rounds down, least init wait rounds up
  localparam int  PLL_LOCK_CYCLES = int'($floor(PLL_LOCK_MS * SYS_CLK_HZ / 1000.0));
  localparam int  CORE_INIT_CYCLES = int'($ceil(CORE_INIT_US * SYS_CLK_HZ / 1000000.0));
  typedef enum logic [1:0] {PLL_OFF, PLL_LOCKING, PLL_LOCKED} pll_state_e;
endpackage

// ==== rtl/buffered_clock_pin_gen.sv ====
// divides sys_clk for the buffered clock pin; half period is 2^sel cycles
module buffered_clock_pin_gen #(
  parameter int SEL_W = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             enable,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  clk_out_q
);
  localparam int CNT_W = (1 << SEL_W) + 1;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             clk_out_d;
  logic [CNT_W-1:0] half;

  always_comb begin
    half      = CNT_W'(1) << sel;
    cnt_d     = cnt_q + CNT_W'(1);
    clk_out_d = clk_out_q;
    if (!enable) begin
      // pin parks low on the next clock after disable, cutting any high phase short
      cnt_d     = '0;
      clk_out_d = 1'b0;
    end else if (cnt_d >= half) begin
      cnt_d     = '0;
      clk_out_d = ~clk_out_q;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q     <= '0;
      clk_out_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      clk_out_q <= clk_out_d;
    end
  end
endmodule

// ==== testbench/dsp_startup_config_sequencer_properties.sv ====
module dsp_startup_seq_checker #(
  parameter int LOCK_CYCLES = 20,
  parameter int INIT_CYCLES = 10
) (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [15:0] ctl_addr,
  input wire logic [15:0] ctl_wdata,
  input wire logic        ctl_wr,
  input wire logic        ctl_rd,
  input wire logic        ctl_ack_q,
  input wire logic        pll_locked_q,
  input wire logic        core_init_busy_q,
  input wire logic        mem_wr_q,
  input wire logic        mem_page_q,
  input wire logic [15:0] mem_addr_q,
  input wire logic [15:0] mem_wdata_q,
  input wire logic [15:0] power_mask_a_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  //==============================================================
  // decoded writes
  wire logic page_wr = ctl_wr && ctl_addr == dsp_startup_pkg::ADDR_MEMORY_PAGE_SELECT;
  wire logic pwr_wr  = ctl_wr && ctl_addr == dsp_startup_pkg::ADDR_SUBSYSTEM_POWER_A;
  wire logic run_any = ctl_wr && ctl_addr == dsp_startup_pkg::ADDR_PLL_RUN_BIT;
  wire logic core_on = ctl_wr && ctl_addr == dsp_startup_pkg::ADDR_CORE_RUN_CONTROL && ctl_wdata[0];
  sequence run_wr(b);
    run_any && ctl_wdata[0] == b;
  endsequence
  //==============================================================
  // properties
  ack_follow_a: assert property ((ctl_wr || ctl_rd) |=> ctl_ack_q)
    else $error("ack missing after request");
  ack_spurious_a: assert property (!(ctl_wr || ctl_rd) |=> !ctl_ack_q)
    else $error("ack without request");
  mem_forward_a: assert property (mem_wr_q |-> $past(ctl_wr) && $past(ctl_addr) < 16'hf000
    && mem_addr_q == $past(ctl_addr) && mem_wdata_q == $past(ctl_wdata))
    else $error("memory write not forwarded intact");
  page_source_a: assert property ($changed(mem_page_q) |-> $past(page_wr)
    && mem_page_q == $past(ctl_wdata[0]))
    else $error("page select changed without its write");
  power_source_a: assert property ($changed(power_mask_a_q) |-> $past(pwr_wr))
    else $error("power mask changed without its write");
  lock_clear_a: assert property (run_wr(1'b0) |=> !pll_locked_q)
    else $error("lock kept after run bit cleared");
  lock_restart_a: assert property (run_wr(1'b1) |=> !pll_locked_q [*8])
    else $error("lock flag set too soon after enable");
  lock_drop_a: assert property ($fell(pll_locked_q) |-> $past(run_any))
    else $error("lock lost without run bit write");
  init_start_a: assert property ($rose(core_init_busy_q) |-> $past(core_on))
    else $error("init busy without core start");
  init_length_a: assert property ($fell(core_init_busy_q) |-> $past(core_init_busy_q, INIT_CYCLES)
    && !$past(core_init_busy_q, INIT_CYCLES + 1))
    else $error("init busy length wrong");
endmodule

bind dsp_startup_config_sequencer dsp_startup_seq_checker #(
  .LOCK_CYCLES(LOCK_CYCLES),
  .INIT_CYCLES(INIT_CYCLES)
) chk_i (.sys_clk, .nrst, .ctl_addr, .ctl_wdata, .ctl_wr, .ctl_rd, .ctl_ack_q, .pll_locked_q,
  .core_init_busy_q, .mem_wr_q, .mem_page_q, .mem_addr_q, .mem_wdata_q, .power_mask_a_q);

// ==== testbench/host_ctl_model.sv ====
module host_ctl_model (
  input  wire logic        sys_clk,
  input  wire logic        ctl_ack_q,
  input  wire logic [15:0] ctl_rdata_q,
  output logic             ctl_wr,
  output logic             ctl_rd,
  output logic [15:0]      ctl_addr,
  output logic [15:0]      ctl_wdata,
  output logic             slave_select_addr0_pin,
  output logic             late
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {ctl_wr, ctl_rd, slave_select_addr0_pin, late} = 4'h0;
    ctl_addr = 16'h0000;
    ctl_wdata = 16'h0000;
  end
  // one strobe cycle, then wait up to 4 cycles for the ack before anything else moves
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge sys_clk);
    ctl_wr <= w;
    ctl_rd <= !w;
    ctl_addr <= a;
    ctl_wdata <= d;
    @(posedge sys_clk);
    ctl_wr <= 1'b0;
    ctl_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ctl_ack_q !== 1'b1 && n < 4);
    if (ctl_ack_q !== 1'b1) late <= 1'b1;
    q = ctl_rdata_q;
    // released lines must not keep looking valid
    ctl_addr <= ~a;
    ctl_wdata <= ~d;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] q);
    xfer(1'b0, a, 16'h0000, q);
  endtask
  task automatic ss_toggle();
    repeat (3) begin
      @(posedge sys_clk);
      slave_select_addr0_pin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      slave_select_addr0_pin <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
endmodule

// ==== testbench/dsp_startup_config_sequencer_tb_top.sv ====
module dsp_startup_config_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOCK = 20;
  localparam int INIT = 10;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        slave_select_addr0_pin, ctl_wr, ctl_rd, ctl_ack_q, spi_mode_q, late;
  logic        buffered_clock_pin, soft_reset_q, pll_locked_q, core_active_q;
  logic        core_init_busy_q, mem_wr_q, mem_page_q;
  logic [15:0] ctl_addr, ctl_wdata, ctl_rdata_q, mem_addr_q, mem_wdata_q;
  logic [15:0] power_mask_a_q, power_mask_b_q, q;
  int          fail_count = 0;
  int          n_compared = 0;
  always #10 sys_clk = ~sys_clk;
  host_ctl_model host (.sys_clk, .ctl_ack_q, .ctl_rdata_q, .ctl_wr, .ctl_rd, .ctl_addr, .ctl_wdata,
    .slave_select_addr0_pin, .late);
  dsp_startup_config_sequencer #(.LOCK_CYCLES(LOCK), .INIT_CYCLES(INIT)) dut (.sys_clk, .nrst,
    .slave_select_addr0_pin, .ctl_addr, .ctl_wdata, .ctl_wr, .ctl_rd, .ctl_rdata_q, .ctl_ack_q,
    .spi_mode_q, .buffered_clock_pin, .soft_reset_q, .pll_locked_q, .core_active_q, .core_init_busy_q,
    .mem_wr_q, .mem_page_q, .mem_addr_q, .mem_wdata_q, .power_mask_a_q, .power_mask_b_q);
  //==============================================================
  // checking
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    if (late !== 1'b0) begin
      fail_count++;
      $display("[ERR] control port ack expected 1 seen 0");
    end
    $display("compares %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  //==============================================================
  // scenarios
  task automatic t_reset_vals();
    host.rd(16'hf000, q);
    chk("feedback divider", 16'h0060, q);
    host.rd(16'hf7ff, q);
    chk("unmapped read", 16'h0000, q);
    chk("clock pin idle", 16'h0000, buffered_clock_pin);
  endtask
  task automatic t_spi_mode();
    host.ss_toggle();
    repeat (2) @(posedge sys_clk);
    chk("spi mode", 16'h0001, spi_mode_q);
  endtask
  task automatic t_soft();
    host.wr(16'hf890, 16'h0000);
    chk("soft reset on", 16'h0001, soft_reset_q);
    host.wr(16'hf890, 16'h0001);
    chk("soft reset off", 16'h0000, soft_reset_q);
  endtask
  task automatic t_pll();
    int n;
    host.wr(16'hf000, 16'h0060);
    host.wr(16'hf001, 16'h0002);
    host.wr(16'hf002, 16'h0001);
    host.wr(16'hf005, 16'h0005);
    n = 0;
    while (buffered_clock_pin !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    while (buffered_clock_pin === 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk("clock half period", 16'h0004, 16'(n));
    host.wr(16'hf003, 16'h0001);
    host.wr(16'hf050, 16'h1234);
    chk("write while locking", 16'h0000, power_mask_a_q);
    host.rd(16'hf004, q);
    chk("lock too early", 16'h0000, q);
    n = 0;
    while (q !== 16'h0001 && n < 40) begin
      host.rd(16'hf004, q);
      n++;
    end
    chk("lock status", 16'h0001, q);
    chk("lock flag", 16'h0001, pll_locked_q);
    if (q !== 16'h0001) print_verdict();
  endtask
  task automatic t_download();
    logic [15:0] base [3] = '{16'hc000, 16'h0000, 16'h6000};
    logic [15:0] d;
    host.wr(16'hf050, 16'h4fff);
    chk("power mask a", 16'h4fff, power_mask_a_q);
    host.wr(16'hf051, 16'hffff);
    chk("power mask b set", 16'hffff, power_mask_b_q);
    host.wr(16'hf051, 16'h0000);
    chk("power mask b", 16'h0000, power_mask_b_q);
    host.wr(16'hf400, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      host.wr(16'hf899, 16'(p));
      foreach (base[i]) begin
        d = ~base[i] ^ 16'(p);
        host.wr(base[i] + 16'h0001, d);
        chk("mem strobe", 16'h0001, mem_wr_q);
        chk("mem addr", base[i] + 16'h0001, mem_addr_q);
        chk("mem data", d, mem_wdata_q);
        chk("mem page", 16'(p), mem_page_q);
      end
    end
  endtask
  task automatic t_core();
    host.wr(16'hf404, 16'h0000);
    host.wr(16'hf401, 16'h0002);
    host.wr(16'hf400, 16'h0000);
    host.wr(16'hf402, 16'h0000);
    host.wr(16'hf402, 16'h0001);
    chk("init busy start", 16'h0001, core_init_busy_q);
    chk("core running", 16'h0001, core_active_q);
    repeat (INIT - 1) @(posedge sys_clk);
    chk("init busy held", 16'h0001, core_init_busy_q);
    @(posedge sys_clk);
    chk("init busy done", 16'h0000, core_init_busy_q);
    host.wr(16'h0002, 16'h0abc);
    chk("live mem strobe", 16'h0001, mem_wr_q);
    chk("core kept running", 16'h0001, core_active_q);
    host.wr(16'hf400, 16'h0001);
    chk("core halted", 16'h0000, core_active_q);
    host.wr(16'hf004, 16'h0000);
    host.rd(16'hf004, q);
    chk("lock status read only", 16'h0001, q);
    host.wr(16'hf003, 16'h0000);
    chk("lock cleared", 16'h0000, pll_locked_q);
  endtask
  //==============================================================
  // main sequence and hang guard
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset_vals();
    t_spi_mode();
    t_soft();
    t_pll();
    t_download();
    t_core();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("[ERR] run length expected done seen timeout");
    print_verdict();
  end
endmodule
